// ### rtl/swat_map.svh
// address map, field codes and reset values of the width translator
`ifndef SWAT_MAP_SVH
`define SWAT_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SWAT_CTRL0_OFF   12'h000
`define SWAT_CTRL1_OFF   12'h004
`define SWAT_STATUS_OFF  12'h008

// ----------------------------------------------------------------------
// size and width codes
// ----------------------------------------------------------------------
`define SWAT_SZ8         2'h0
`define SWAT_SZ16        2'h1
`define SWAT_SZ32        2'h3

// ----------------------------------------------------------------------
// reset values and map
// ----------------------------------------------------------------------
`define SWAT_CTRL_RST    10'h00F
`define SWAT_BANK1_BASE  24'h90_0000
`define SWAT_MASK8       32'h0000_00FF
`define SWAT_MASK16      32'h0000_FFFF
`define SWAT_MASK32      32'hFFFF_FFFF

`endif

// ### rtl/swat_pkg.sv
// types shared by the width translator and its lane decoder
`include "swat_map.svh"

package swat_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic {
    PH_IDLE   = 1'b0,
    PH_STROBE = 1'b1
  } phase_t;

  typedef struct packed {
    logic       shared;
    logic [4:0] wait_states;
    logic [1:0] mem_width;
    logic [1:0] data_size;
  } ctrl_t;

  typedef struct packed {
    logic [25:0] pin_addr;
    logic [3:0]  lanes;
    logic [1:0]  off;
    logic [1:0]  dsh;
    logic [1:0]  wsh;
    logic [1:0]  nsh;
    logic [2:0]  ncyc;
  } dec_t;

  typedef struct packed {
    phase_t      phase;
    logic [1:0]  cyc;
    logic [4:0]  wcnt;
    logic        bank1;
    logic        wr;
    logic [23:0] laddr;
    logic [31:0] wdata;
    logic [31:0] racc;
    logic [1:0]  off;
    logic [1:0]  dsh;
    logic [1:0]  wsh;
    logic [1:0]  nsh;
    logic [2:0]  ncyc;
    ctrl_t       ctrl0;
    ctrl_t       ctrl1;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        req_ready;
    logic        rsp_valid;
    logic [31:0] rsp_rdata;
    logic [23:0] mem_addr;
    logic [3:0]  b0_n;
    logic [3:0]  b1_n;
    logic        we_n;
    logic        doe;
    logic [31:0] dout;
    logic [7:0]  xfer_cnt;
  } state_t;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] log2_code(input logic [1:0] code);
    unique case (code)
      `SWAT_SZ8:  log2_code = 2'h0;
      `SWAT_SZ16: log2_code = 2'h1;
      default:    log2_code = 2'h2;
    endcase
  endfunction : log2_code

  function automatic logic [31:0] size_mask(input logic [1:0] sh);
    unique case (sh)
      2'h0:    size_mask = `SWAT_MASK8;
      2'h1:    size_mask = `SWAT_MASK16;
      default: size_mask = `SWAT_MASK32;
    endcase
  endfunction : size_mask

endpackage : swat_pkg

// ### rtl/lane_decode.sv
// logical to physical address, lane and cycle-count decoding
`timescale 1ns/100ps
`default_nettype none

module lane_decode
  import swat_pkg::*;
(
  input  wire logic [1:0]  data_size,
  input  wire logic [1:0]  mem_width,
  input  wire logic [23:0] laddr,
  input  wire logic [1:0]  cyc,
  output dec_t             dec
);

  logic [25:0] full;
  logic [25:0] wmask;
  logic [2:0]  cnt;
  logic [3:0]  ones;

  always_comb begin
    dec.dsh      = log2_code(data_size);
    dec.wsh      = log2_code(mem_width);
    dec.nsh      = (dec.dsh < dec.wsh) ? dec.dsh : dec.wsh;
    // shift by data size, then step by memory width per bus cycle
    full         = (26'(laddr) << dec.dsh) + (26'(cyc) << dec.wsh); // RULE4 RULE15
    wmask        = (26'h1 << dec.wsh) - 26'h1;
    dec.pin_addr = full & ~wmask; // RULE1 RULE7
    dec.off      = full[1:0] & wmask[1:0];
    cnt          = 3'(3'h1 << dec.nsh);
    ones         = 4'((5'h1 << cnt) - 5'h1);
    dec.lanes    = 4'(ones << dec.off); // RULE6 RULE13 RULE14
    dec.ncyc     = (dec.dsh > dec.wsh) ? 3'(3'h1 << (dec.dsh - dec.wsh)) : 3'h1; // RULE2 RULE3
  end

endmodule : lane_decode

`default_nettype wire

// ### rtl/strobe_width_address_translator.sv
// external memory width translator with apb control registers
//
// How it works
// RULE1: equal sizes shift address by width only
// RULE2: 32-bit datum to 16-bit memory: two cycles
// RULE3: 16-bit datum to byte memory: two cycles
// RULE4: extra low address bits count bus cycles
// RULE5: write data truncated to configured data size
// RULE6: logical lsb picks lane in 16-bit memory
// RULE7: remaining address bits start at minus-one pin
// RULE8: board wires minus pins to memory address zero
// RULE9: translation set only by size and width fields
// RULE10: shared mode routes both strobes to bank zero
// RULE11: address range picks governing strobe settings
// RULE12: each strobe keeps its own settings when shared
// RULE13: 16-bit in 32-bit: lsb picks lane pair
// RULE14: 8-bit in 32-bit: one lane by two lsbs
// RULE15: high address bits follow data size shift
// RULE16: software keeps ranges inside strobe blocks
// RULE17: programmed wait states in every bus cycle
// RULE18: narrow memory reuses lanes three, two as address
// RULE19: least significant part at lowest address first
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module strobe_width_address_translator
  import swat_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [23:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic      [31:0] rsp_rdata,
  input  wire logic [31:0] mem_din,
  output logic      [31:0] mem_dout,
  output logic             mem_doe,
  output logic             mem_we_n,
  output logic      [23:0] mem_addr,
  output logic      [3:0]  bank_zero_strobe_n,
  output logic      [3:0]  bank_one_strobe_n
);

  // ----------------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------------
  state_t      q;
  state_t      d;
  dec_t        dec;
  ctrl_t       dec_ctrl;
  logic        accept;
  logic        last_wait;
  logic        last_cyc;
  logic        dec_bank1;
  logic [23:0] dec_addr;
  logic [1:0]  dec_cyc;
  logic [31:0] sample;
  logic [31:0] racc_new;

  assign accept    = (q.phase == PH_IDLE) && req_valid && q.req_ready;
  assign last_wait = (q.phase == PH_STROBE) && (q.wcnt == 5'h0);
  assign last_cyc  = (3'(q.cyc) + 3'h1) == q.ncyc;
  assign dec_addr  = accept ? req_addr : q.laddr;
  assign dec_cyc   = accept ? 2'h0 : 2'(q.cyc + 2'h1);
  assign dec_bank1 = dec_addr >= `SWAT_BANK1_BASE; // RULE11
  assign dec_ctrl  = dec_bank1 ? q.ctrl1 : q.ctrl0; // RULE12
  // least significant portion lands in the first, lowest cycle
  assign sample    = ((mem_din >> {q.off, 3'h0}) & size_mask(q.nsh))
                     << 5'({q.cyc, 3'h0} << q.wsh); // RULE19
  assign racc_new  = q.racc | sample;

  lane_decode u_dec (
    .data_size (dec_ctrl.data_size), // RULE9
    .mem_width (dec_ctrl.mem_width),
    .laddr     (dec_addr),
    .cyc       (dec_cyc),
    .dec       (dec)
  );

  // ----------------------------------------------------------------------
  // one bus cycle drive
  // ----------------------------------------------------------------------
  function automatic state_t drive_cycle(input state_t s, input dec_t dc, input ctrl_t c,
                                         input logic bank1, input logic shared);
    logic [3:0] strb;
    strb = ~dc.lanes;
    if (dc.wsh == 2'h1) begin
      strb[3] = dc.pin_addr[1]; // RULE18
      strb[2] = 1'b1;
    end else if (dc.wsh == 2'h0) begin
      strb[3] = dc.pin_addr[1]; // RULE18
      strb[2] = dc.pin_addr[0];
    end
    s.mem_addr = dc.pin_addr[25:2];
    s.b0_n     = (bank1 && !shared) ? 4'hF : strb; // RULE10
    s.b1_n     = (bank1 && !shared) ? strb : 4'hF;
    s.we_n     = !s.wr;
    s.doe      = s.wr;
    s.dout     = (s.wdata >> 5'({s.cyc, 3'h0} << dc.wsh)) << {dc.off, 3'h0}; // RULE19
    s.wcnt     = c.wait_states; // RULE17
    s.off      = dc.off;
    s.dsh      = dc.dsh;
    s.wsh      = dc.wsh;
    s.nsh      = dc.nsh;
    drive_cycle = s;
  endfunction : drive_cycle

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    // apb: one wait cycle, write lands on the completing edge
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      unique case (paddr)
        `SWAT_CTRL0_OFF:  d.prdata = 32'(q.ctrl0);
        `SWAT_CTRL1_OFF:  d.prdata = 32'(q.ctrl1);
        `SWAT_STATUS_OFF: d.prdata = {16'h0, q.xfer_cnt, 6'h0, q.bank1, q.phase};
        default: begin
          d.prdata  = 32'h0;
          d.pslverr = 1'b1;
        end
      endcase
    end else if (q.pready) begin
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      if (psel && penable && pwrite) begin
        if (paddr == `SWAT_CTRL0_OFF) begin
          d.ctrl0 = ctrl_t'(pwdata[9:0]);
        end else if (paddr == `SWAT_CTRL1_OFF) begin
          d.ctrl1 = ctrl_t'(pwdata[9:0]);
          d.ctrl1.shared = 1'b0;
        end
      end
    end
    unique case (q.phase)
      PH_IDLE: begin
        if (accept) begin
          d.phase     = PH_STROBE;
          d.req_ready = 1'b0;
          d.laddr     = req_addr;
          d.wr        = req_write;
          d.bank1     = dec_bank1;
          d.wdata     = req_wdata & size_mask(dec.dsh); // RULE5
          d.racc      = 32'h0;
          d.cyc       = 2'h0;
          d.ncyc      = dec.ncyc;
          d = drive_cycle(d, dec, dec_ctrl, dec_bank1, q.ctrl0.shared);
        end
      end
      PH_STROBE: begin
        if (q.wcnt != 5'h0) begin
          d.wcnt = 5'(q.wcnt - 5'h1); // RULE17
        end else begin
          if (!q.wr) begin
            d.racc = racc_new;
          end
          if (last_cyc) begin
            d.phase     = PH_IDLE;
            d.req_ready = 1'b1;
            d.rsp_valid = 1'b1;
            d.rsp_rdata = q.wr ? 32'h0 : racc_new;
            d.b0_n      = 4'hF;
            d.b1_n      = 4'hF;
            d.we_n      = 1'b1;
            d.doe       = 1'b0;
            d.xfer_cnt  = 8'(q.xfer_cnt + 8'h1);
          end else begin
            d.cyc = 2'(q.cyc + 2'h1); // RULE2 RULE3 RULE4
            d = drive_cycle(d, dec, dec_ctrl, q.bank1, q.ctrl0.shared);
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.phase     <= PH_IDLE;
      q.ctrl0     <= ctrl_t'(`SWAT_CTRL_RST);
      q.ctrl1     <= ctrl_t'(`SWAT_CTRL_RST);
      q.req_ready <= 1'b1;
      q.b0_n      <= 4'hF;
      q.b1_n      <= 4'hF;
      q.we_n      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign req_ready          = q.req_ready;
  assign rsp_valid          = q.rsp_valid;
  assign rsp_rdata          = q.rsp_rdata;
  assign mem_dout           = q.dout;
  assign mem_doe            = q.doe;
  assign mem_we_n           = q.we_n;
  assign mem_addr           = q.mem_addr;
  assign bank_zero_strobe_n = q.b0_n;
  assign bank_one_strobe_n  = q.b1_n;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [8:0] len_h;
  logic [2:0] ncyc_h;
  logic [2:0] nbus_h;
  logic [4:0] ws_h;
  logic [3:0] act_n;

  assign act_n = (q.bank1 && !q.ctrl0.shared) ? q.b1_n : q.b0_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_h  <= 9'h0;
      ncyc_h <= 3'h0;
      nbus_h <= 3'h0;
      ws_h   <= 5'h0;
    end else if (accept) begin
      len_h  <= 9'h0;
      nbus_h <= 3'h0;
      ncyc_h <= dec.ncyc;
      ws_h   <= dec_ctrl.wait_states;
    end else if (q.phase == PH_STROBE) begin
      len_h  <= 9'(len_h + 9'h1);
      nbus_h <= last_wait ? 3'(nbus_h + 3'h1) : nbus_h;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence take_req;
    req_valid && q.req_ready && (q.phase == PH_IDLE);
  endsequence

  sequence bus_busy;
    !q.req_ready && (q.phase == PH_STROBE);
  endsequence

  req_taken_a: assert property (take_req |=> bus_busy) // RULE9
    else $error("request not taken into a bus cycle");
  wait_len_a: assert property ($rose(q.rsp_valid) |-> len_h == 9'(ncyc_h * (ws_h + 5'h1))) // RULE17
    else $error("transfer length does not match wait states");
  bus_cycles_a: assert property ($rose(q.rsp_valid) |-> nbus_h == ncyc_h) // RULE2
    else $error("wrong number of bus cycles");
  shared_route_a: assert property ((q.phase == PH_STROBE) && q.ctrl0.shared
                                   |-> q.b1_n == 4'hF) // RULE10
    else $error("second bank pins used in shared mode");
  one_lane_a: assert property ((q.phase == PH_STROBE) && (q.wsh == 2'h2)
                               |-> $countones(~act_n) == (1 << q.nsh)) // RULE14
    else $error("wrong lane count on wide memory");
  upper_pair_a: assert property ((q.phase == PH_STROBE) && (q.wsh == 2'h2) && (q.dsh == 2'h1)
                                 && q.laddr[0] |-> act_n == 4'h3) // RULE13
    else $error("odd halfword not on upper lane pair");
  byte_pins_a: assert property ((q.phase == PH_STROBE) && (q.wsh == 2'h0) && (q.dsh == 2'h0)
                                |-> act_n[3:2] == q.laddr[1:0]
                                    && q.mem_addr == q.laddr[23:2]) // RULE18
    else $error("byte memory address pins wrong");
  word_addr_a: assert property ((q.phase == PH_STROBE) && (q.wsh == 2'h2) && (q.dsh == 2'h2)
                                |-> q.mem_addr == q.laddr) // RULE1
    else $error("word address changed on word memory");
  trunc_a: assert property ((take_req and (req_write && (dec.dsh == 2'h0)))
                            |=> q.wdata[31:8] == 24'h0) // RULE5
    else $error("byte write not truncated");
  idle_quiet_a: assert property ((q.phase == PH_IDLE) |-> q.b0_n == 4'hF && !q.doe) // RULE12
    else $error("strobes active while idle");

endmodule : strobe_width_address_translator

`default_nettype wire

// ### testbench/sram_lane_model.sv
// lane-addressed memory model standing on both strobe spaces
`timescale 1ns/100ps
`default_nettype none

module sram_lane_model (
  input  wire logic        pclk,
  input  wire logic [1:0]  width0,
  input  wire logic [1:0]  width1,
  input  wire logic [23:0] mem_addr,
  input  wire logic [3:0]  s0_n,
  input  wire logic [3:0]  s1_n,
  input  wire logic        we_n,
  input  wire logic [31:0] dout,
  output logic      [31:0] din
);
  logic [7:0]  mem [int];
  logic [31:0] last_q = 32'h5A5A_0F0F;
  logic        act_q  = 1'b0;
  logic        act;
  logic        bk;
  logic [1:0]  w;
  logic [3:0]  s;
  logic [3:0]  lane_on;
  int          fk;
  int          first_key;

  function automatic int nl(input logic [1:0] wc);
    return (wc == 2'h0) ? 1 : (wc == 2'h1) ? 2 : 4;
  endfunction : nl

  function automatic int key(input logic b, input logic [1:0] wc, input logic [3:0] sn,
                             input logic [23:0] ad, input int l);
    logic [1:0] low;
    low = (wc == 2'h0) ? {sn[3], sn[2]} : (wc == 2'h1) ? {sn[3], l[0]} : l[1:0];
    return {5'h00, b, ad, low};
  endfunction : key

  // ----------------------------------------------------------------------
  // read path, released lanes show the inverse of the last value
  // ----------------------------------------------------------------------
  always @* begin
    bk = 1'b0;
    for (int l = 0; l < 4; l++) if (!s1_n[l] && l < nl(width1)) bk = 1'b1;
    w = bk ? width1 : width0;
    s = bk ? s1_n : s0_n;
    act = 1'b0;
    fk = 0;
    din = ~last_q;
    for (int l = 3; l >= 0; l--) begin
      lane_on[l] = !s[l] && l < nl(w);
      if (lane_on[l]) begin
        act = 1'b1;
        fk = key(bk, w, s, mem_addr, l);
        if (we_n && mem.exists(fk)) din[8*l +: 8] = mem[fk];
      end
    end
  end

  // ----------------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------------
  always @(posedge pclk) begin
    last_q <= din;
    act_q <= act;
    if (act && !act_q) first_key <= fk;
    for (int l = 0; l < 4; l++) begin
      if (act && !we_n && lane_on[l]) mem[key(bk, w, s, mem_addr, l)] = dout[8*l +: 8];
    end
  end
endmodule : sram_lane_model

`default_nettype wire

// ### testbench/strobe_width_address_translator_test.sv
// self-checking bench of the width translator
`timescale 1ns/100ps
`default_nettype none
`include "swat_map.svh"

module strobe_width_address_translator_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, req_wdata, rsp_rdata, mem_din, mem_dout, rd, d, mask;
  logic        req_valid, req_write, req_ready, rsp_valid, mem_doe, mem_we_n;
  logic [23:0] req_addr, mem_addr, a;
  logic [3:0]  b0_n, b1_n;
  logic [1:0]  cw0, cw1;
  logic [9:0]  ctl;
  logic        shared_on, b1_bad, doe_bad;
  int          num_errors, cmp_count, cyc_count, n, nb, ds, ws, nc, kb, base, bytes_sum;
  logic [9:0]  c0_tab [5] = '{10'h00F, 10'h20D, 10'h007, 10'h014, 10'h000};
  logic [9:0]  c1_tab [5] = '{10'h01C, 10'h03C, 10'h021, 10'h005, 10'h013};

  strobe_width_address_translator dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_din(mem_din), .mem_dout(mem_dout), .mem_doe(mem_doe),
    .mem_we_n(mem_we_n), .mem_addr(mem_addr), .bank_zero_strobe_n(b0_n),
    .bank_one_strobe_n(b1_n));

  sram_lane_model mem_u (
    .pclk(pclk), .width0(cw0), .width1(cw1), .mem_addr(mem_addr), .s0_n(b0_n),
    .s1_n(b1_n), .we_n(mem_we_n), .dout(mem_dout), .din(mem_din));

  // ----------------------------------------------------------------------
  // clock, timeout and shared-mode watch
  // ----------------------------------------------------------------------
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc_count++;
    if (shared_on && b1_n !== 4'hF) b1_bad = 1'b1;
    if (presetn === 1'b1 && mem_doe !== !mem_we_n) doe_bad = 1'b1;
    if (cyc_count == 10000) begin
      num_errors++;
      $display("ERROR at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic core(input logic wr, input logic [23:0] ad, input logic [31:0] wd);
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= ad;
    req_wdata <= wd;
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin @(posedge pclk); n++; end while (rsp_valid !== 1'b1);
    rd = rsp_rdata;
  endtask : core

  function automatic int sh(input logic [1:0] c);
    return (c == 2'h0) ? 0 : (c == 2'h1) ? 1 : 2;
  endfunction : sh

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; req_valid = 1'b0; req_write = 1'b0;
    req_addr = 24'h00_0000; req_wdata = 32'h0000_0000; cw0 = 2'h3; cw1 = 2'h3;
    shared_on = 1'b0; b1_bad = 1'b0; num_errors = 0; cmp_count = 0; cyc_count = 0;
    doe_bad = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SWAT_CTRL0_OFF, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    apb(1'b0, `SWAT_CTRL1_OFF, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, `SWAT_CTRL1_OFF, 32'hFFFF_FFFF);
    apb(1'b0, `SWAT_CTRL1_OFF, 32'h0000_0000);
    check(rd, 32'h0000_01FF);
    $display("test registers done");
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `SWAT_CTRL0_OFF, {22'h00_0000, c0_tab[c]});
      apb(1'b1, `SWAT_CTRL1_OFF, {22'h00_0000, c1_tab[c]});
      cw0 = c0_tab[c][3:2];
      cw1 = c1_tab[c][3:2];
      shared_on = c0_tab[c][9];
      b1_bad = 1'b0;
      bytes_sum = 0;
      mem_u.mem.delete();
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < 4; i++) begin
          ctl = b ? c1_tab[c] : c0_tab[c];
          ds = sh(ctl[1:0]);
          ws = sh(ctl[3:2]);
          nb = 1 << ds;
          nc = (ds > ws) ? (1 << (ds - ws)) : 1;
          a = (b ? `SWAT_BANK1_BASE : 24'h00_0000) + 24'h00_0040 + 24'(i);
          d = 32'h1357_9BDF + 32'h1111_1111 * 32'(i + 4 * b);
          mask = (nb == 4) ? 32'hFFFF_FFFF : (32'h0000_0001 << (8 * nb)) - 32'h0000_0001;
          kb = (b == 1 && !shared_on) ? 1 : 0;
          base = (kb << 26) | (int'(a) << ds);
          core(1'b1, a, d);
          check(32'(n), 32'(nc * (ctl[8:4] + 1) + 1));
          check(32'(mem_u.first_key), 32'(base));
          for (int k = 0; k < nb; k++) begin
            check({24'h00_0000, mem_u.mem[base + k]}, {24'h00_0000, d[8*k +: 8]});
          end
          core(1'b0, a, 32'h0000_0000);
          check(rd, d & mask);
          check(32'(n), 32'(nc * (ctl[8:4] + 1) + 1));
          bytes_sum += nb;
        end
      end
      check(32'(mem_u.mem.num()), 32'(bytes_sum));
      check({31'h0000_0000, b1_bad}, 32'h0000_0000);
      $display("test config %0d done", c);
    end
    apb(1'b0, `SWAT_STATUS_OFF, 32'h0000_0000);
    check(rd, 32'h0000_5002);
    check({31'h0000_0000, doe_bad}, 32'h0000_0000);
    $display("test status done");
    tally_and_finish();
  end
endmodule : strobe_width_address_translator_test

`default_nettype wire
